// ===== core/otm_encoder.sv
/*
 * otm_encoder: per-subcarrier tone mapping, pilot placement, pseudo-random
 * loading and constellation encoding with gain and normalization.
 * assumes: upstream gives one configuration per symbol, then the symbol's
 * subcarriers in ascending index order, and frame bits four at a time.
 */
`timescale 1ns/1ps
module otm_encoder (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_sym_valid,
	input wire otm_pkg::otm_sym_cfg_t i_sym_cfg,
	output logic o_sym_ready,
	input wire logic i_sc_valid,
	input wire otm_pkg::otm_sc_t i_sc,
	output logic o_sc_ready,
	input wire logic i_data_valid,
	input wire logic [3:0] i_data,
	output logic o_data_take,
	output logic [2:0] o_data_take_cnt,
	output logic o_z_valid,
	output otm_pkg::otm_z_t o_z,
	input wire logic i_z_ready,
	output logic [otm_pkg::SYM_W-1:0] o_sym_index,
	output logic [otm_pkg::M_W-1:0] o_pilot_count,
	output logic o_cfg_error
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SYM = 2'b01
	} otm_state_t;

	otm_state_t state;
	otm_state_t next_state;

	// per-symbol context
	logic payload;
	logic rmsc_loaded;
	logic [2:0] load;
	logic [otm_pkg::M_W-1:0] m_count;
	logic [otm_pkg::M_W+4-1:0] pilot_span;
	logic [otm_pkg::M_W-1:0] t_pos;
	logic [otm_pkg::ACC_W-1:0] acc;
	logic [otm_pkg::GAIN_W-1:0] gain;
	logic [otm_pkg::GAIN_W-1:0] isc_gain;
	logic seen_payload;

	function automatic logic [otm_pkg::M_W-1:0] mod_n(input logic [otm_pkg::M_W-1:0] v);
		return v % otm_pkg::PILOT_SPACING;
	endfunction : mod_n

	function automatic logic [2:0] bat_bits(input logic [3:0] bit_allocation_table);
		case (bit_allocation_table)
			otm_pkg::BAT_T0, otm_pkg::BAT_T1, otm_pkg::BAT_T2: bat_bits = otm_pkg::LOAD_2;
			otm_pkg::BAT_T4: bat_bits = otm_pkg::LOAD_4;
			otm_pkg::BAT_T5, otm_pkg::BAT_T6, otm_pkg::BAT_T7: bat_bits = otm_pkg::LOAD_1;
			default: bat_bits = otm_pkg::LOAD_NONE;
		endcase
	endfunction : bat_bits

	function automatic logic signed [2:0] lvl2(input logic b);
		return b ? 3'sh1 : -3'sh1;
	endfunction : lvl2

	function automatic logic signed [2:0] lvl4(input logic [1:0] pr);
		case (pr)
			2'b00: lvl4 = -3'sh3;
			2'b10: lvl4 = -3'sh1;
			2'b11: lvl4 = 3'sh1;
			default: lvl4 = 3'sh3;
		endcase
	endfunction : lvl4

	function automatic logic signed [otm_pkg::Z_W-1:0] scale(
		input logic signed [2:0] lvl,
		input logic [otm_pkg::AMP_W-1:0] amp
	);
		logic signed [31:0] prod;
		prod = 32'(lvl) * 32'($signed({1'b0, amp}));
		return prod[otm_pkg::CHI_FRAC +: otm_pkg::Z_W];
	endfunction : scale

	// ---- symbol start: pilot geometry
	wire start = i_sym_valid && o_sym_ready;
	wire [otm_pkg::M_W-1:0] m_in = i_sym_cfg.m_count;
	wire [otm_pkg::ACC_W-1:0] acc_now = i_sym_cfg.first ? '0
		: otm_pkg::ACC_W'(acc + otm_pkg::ACC_W'(otm_pkg::PILOT_SHIFT));
	wire [otm_pkg::M_W-1:0] m_mod = mod_n(m_in);
	wire [otm_pkg::ACC_W-1:0] base = otm_pkg::ACC_W'(acc_now + otm_pkg::ACC_W'(m_mod));
	wire [otm_pkg::M_W-1:0] s_now = (m_in == '0) ? '0
		: otm_pkg::M_W'(base % otm_pkg::ACC_W'(m_in));
	wire ceil_sel = m_mod >= otm_pkg::PILOT_SHIFT;
	wire [otm_pkg::M_W-1:0] p_now = otm_pkg::M_W'(m_in / otm_pkg::PILOT_SPACING)
		+ otm_pkg::M_W'(ceil_sel);
	wire [otm_pkg::M_W+4-1:0] span_now = (otm_pkg::M_W+4)'(p_now)
		* (otm_pkg::M_W+4)'(otm_pkg::PILOT_SPACING);
	wire [otm_pkg::M_W-1:0] t_init = (s_now == '0) ? '0 : otm_pkg::M_W'(m_in - s_now);

	// header always type 0, robust payload forced to type 0 when table illegal
	wire bad_robust = i_sym_cfg.payload && i_sym_cfg.robust && (i_sym_cfg.bit_allocation_table > otm_pkg::BAT_T1);
	wire [3:0] eff_bat = (!i_sym_cfg.payload || bad_robust) ? otm_pkg::BAT_T0
		: i_sym_cfg.bit_allocation_table;
	wire [2:0] load_now = bat_bits(eff_bat);
	wire rmsc_now = (eff_bat == otm_pkg::BAT_T0) || (eff_bat == otm_pkg::BAT_T7);
	wire isc_seed = start && i_sym_cfg.payload && (i_sym_cfg.first || !seen_payload);
	wire next_seen = i_sym_cfg.payload || (seen_payload && !i_sym_cfg.first);
	wire [otm_pkg::SYM_W-1:0] next_sym_index = i_sym_cfg.first ? otm_pkg::SYM_W'(1)
		: otm_pkg::SYM_W'(o_sym_index + 1'b1);
	wire next_cfg_error = bad_robust || (load_now == otm_pkg::LOAD_NONE);

	// ---- per subcarrier classification
	wire kind_sup = i_sc.kind == otm_pkg::SC_SUPPORTED;
	wire kind_isc = i_sc.kind == otm_pkg::SC_INACTIVE;
	wire kind_reg = i_sc.kind == otm_pkg::SC_REG_MASKED;
	wire kind_mask = (i_sc.kind == otm_pkg::SC_PERM_MASKED) || kind_reg;
	wire is_inact = payload && kind_isc;
	wire enumerated = kind_sup || (kind_isc && !payload);
	wire is_pilot = enumerated && (mod_n(t_pos) == '0)
		&& ((otm_pkg::M_W+4)'(t_pos) < pilot_span);
	wire is_data = (enumerated && !is_pilot) || (kind_reg && rmsc_loaded);
	wire need_bits = is_data && (load != otm_pkg::LOAD_NONE);
	wire out_free = !o_z_valid || i_z_ready;
	wire take = i_sc_valid && o_sc_ready;
	wire [otm_pkg::M_W-1:0] t_inc = otm_pkg::M_W'(t_pos + 1'b1);
	wire [otm_pkg::M_W-1:0] next_t = (t_inc == m_count) ? '0 : t_inc;

	assign o_sym_ready = state == ST_IDLE;
	assign o_sc_ready = (state == ST_SYM) && out_free && (!need_bits || i_data_valid);
	assign o_data_take = take && need_bits;
	assign o_data_take_cnt = load;

	// shift register controls
	wire psc_load = start && i_sym_cfg.first;
	wire psc_step = take && is_pilot;
	wire isc_step = take && is_inact;
	wire sc_last_taken = take && i_sc.last;

	// ---- bit sources
	logic [1:0] psc_bits;
	logic [1:0] isc_bits;

	otm_lfsr #(
		.SEED(otm_pkg::PSC_SEED)
	) u_psc_lfsr (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_load(psc_load),
		.i_step(psc_step),
		.o_bits(psc_bits)
	);

	otm_lfsr #(
		.SEED(otm_pkg::ISC_SEED)
	) u_isc_lfsr (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_load(isc_seed),
		.i_step(isc_step),
		.o_bits(isc_bits)
	);

	// ---- constellation levels
	wire [1:0] aux_bits = is_pilot ? psc_bits : isc_bits;
	wire aux_sc = is_pilot || is_inact;
	wire [2:0] eff_load = aux_sc ? otm_pkg::LOAD_2 : load;
	wire signed [2:0] lvl_i = aux_sc ? lvl2(aux_bits[0])
		: (load == otm_pkg::LOAD_4) ? lvl4(i_data[1:0])
		: lvl2(i_data[0]);
	wire signed [2:0] lvl_q = aux_sc ? lvl2(aux_bits[1])
		: (load == otm_pkg::LOAD_4) ? lvl4(i_data[3:2])
		: (load == otm_pkg::LOAD_2) ? lvl2(i_data[1])
		: 3'sh0;
	wire [otm_pkg::CHI_W-1:0] chi = (eff_load == otm_pkg::LOAD_4) ? otm_pkg::CHI_B4
		: (eff_load == otm_pkg::LOAD_2) ? otm_pkg::CHI_B2
		: otm_pkg::CHI_B1;
	wire zero_out = kind_mask || (eff_load == otm_pkg::LOAD_NONE);
	wire [otm_pkg::GAIN_W-1:0] g_sel = zero_out ? '0 : (is_inact ? isc_gain : gain);
	wire [otm_pkg::AMP_W-1:0] amp = otm_pkg::AMP_W'(g_sel) * otm_pkg::AMP_W'(chi);
	otm_pkg::otm_z_t next_z;
	assign next_z.re = scale(lvl_i, amp);
	assign next_z.im = scale(lvl_q, amp);
	assign next_z.last = i_sc.last;

	// ---- sequencing
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (start) begin
					next_state = ST_SYM;
				end
			end
			ST_SYM: begin
				if (sc_last_taken) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// symbol kind and loading captured at symbol start
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			payload <= 1'b0;
			rmsc_loaded <= 1'b0;
			load <= otm_pkg::LOAD_NONE;
		end else if (start) begin
			payload <= i_sym_cfg.payload;
			rmsc_loaded <= rmsc_now;
			load <= load_now;
		end
	end

	// pilot geometry of the running symbol
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			m_count <= '0;
			pilot_span <= '0;
		end else if (start) begin
			m_count <= m_in;
			pilot_span <= span_now;
		end
	end

	// pilot shift accumulator, (j-1)k
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			acc <= '0;
		end else if (start) begin
			acc <= acc_now;
		end
	end

	// gains of the running symbol
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			gain <= '0;
			isc_gain <= '0;
		end else if (start) begin
			gain <= i_sym_cfg.gain;
			isc_gain <= i_sym_cfg.isc_gain;
		end
	end

	// payload already started in this frame
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			seen_payload <= 1'b0;
		end else if (start) begin
			seen_payload <= next_seen;
		end
	end

	// symbol counter j
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_sym_index <= '0;
		end else if (start) begin
			o_sym_index <= next_sym_index;
		end
	end

	// pilot count of the running symbol
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_pilot_count <= '0;
		end else if (start) begin
			o_pilot_count <= p_now;
		end
	end

	// configuration error flag, one value per symbol
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_cfg_error <= 1'b0;
		end else if (start) begin
			o_cfg_error <= next_cfg_error;
		end
	end

	// enumerated position relative to this symbol's first pilot
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			t_pos <= '0;
		end else if (start) begin
			t_pos <= t_init;
		end else if (take && enumerated) begin
			t_pos <= next_t;
		end
	end

	// output word valid until the modulator takes it
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_z_valid <= 1'b0;
		end else if (take) begin
			o_z_valid <= 1'b1;
		end else if (i_z_ready) begin
			o_z_valid <= 1'b0;
		end
	end

	// output word loaded on each accepted subcarrier
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_z <= '0;
		end else if (take) begin
			o_z <= next_z;
		end
	end
endmodule : otm_encoder

// ===== core/otm_lfsr.sv
/*
 * otm_lfsr: seven-stage shift register, x^7 + x^4 + 1, two bits per step.
 * assumes: load and step come from logic on the same clock.
 */
`timescale 1ns/1ps
module otm_lfsr #(
	parameter logic [6:0] SEED = otm_pkg::ISC_SEED
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_load,
	input wire logic i_step,
	output logic [1:0] o_bits
);
	logic [6:0] state;
	logic [6:0] next_state;

	// stage c1 is bit 0; shifts toward bit 0
	function automatic logic [6:0] step1(input logic [6:0] s);
		return {s[0] ^ s[3], s[6:1]};
	endfunction : step1

	assign next_state = step1(step1(state));
	assign o_bits = state[1:0];

	always_ff @(posedge i_clk) begin
		if (i_srst || i_load) begin
			state <= SEED;
		end else if (i_step) begin
			state <= next_state;
		end
	end
endmodule : otm_lfsr

// ===== core/otm_pkg.sv
/*
 * otm_pkg: widths, constants, subcarrier kinds and carrier structs for the
 * tone map and constellation encoder.
 * assumes: one clock domain; upstream supplies per-symbol configuration.
 */
package otm_pkg;
	localparam int M_W = 9;
	localparam int SYM_W = 12;
	localparam int ACC_W = 14;
	localparam int GAIN_W = 12;
	localparam int CHI_W = 15;
	localparam int CHI_FRAC = 14;
	localparam int AMP_W = GAIN_W + CHI_W;
	localparam int Z_W = 18;

	// pilot spacing and per-symbol pilot shift
	localparam logic [M_W-1:0] PILOT_SPACING = 9'h00C;
	localparam logic [M_W-1:0] PILOT_SHIFT = 9'h003;

	// shift register presets
	localparam logic [6:0] ISC_SEED = 7'h7F;
	localparam logic [6:0] PSC_SEED = 7'h7F;

	// power normalization, unsigned with CHI_FRAC fraction bits
	localparam logic [CHI_W-1:0] CHI_B1 = 15'h4000;
	localparam logic [CHI_W-1:0] CHI_B2 = 15'h2D41;
	localparam logic [CHI_W-1:0] CHI_B4 = 15'h143D;

	// bit allocation table types
	localparam logic [3:0] BAT_T0 = 4'h0;
	localparam logic [3:0] BAT_T1 = 4'h1;
	localparam logic [3:0] BAT_T2 = 4'h2;
	localparam logic [3:0] BAT_T3 = 4'h3;
	localparam logic [3:0] BAT_T4 = 4'h4;
	localparam logic [3:0] BAT_T5 = 4'h5;
	localparam logic [3:0] BAT_T6 = 4'h6;
	localparam logic [3:0] BAT_T7 = 4'h7;

	// loaded bits per subcarrier
	localparam logic [2:0] LOAD_NONE = 3'h0;
	localparam logic [2:0] LOAD_1 = 3'h1;
	localparam logic [2:0] LOAD_2 = 3'h2;
	localparam logic [2:0] LOAD_4 = 3'h4;

	typedef enum logic [1:0] {
		SC_PERM_MASKED = 2'b00,
		SC_REG_MASKED = 2'b01,
		SC_INACTIVE = 2'b10,
		SC_SUPPORTED = 2'b11
	} otm_sc_kind_t;

	typedef struct packed {
		logic first;
		logic payload;
		logic robust;
		logic [3:0] bit_allocation_table;
		logic [M_W-1:0] m_count;
		logic [GAIN_W-1:0] gain;
		logic [GAIN_W-1:0] isc_gain;
	} otm_sym_cfg_t;

	typedef struct packed {
		otm_sc_kind_t kind;
		logic last;
	} otm_sc_t;

	typedef struct packed {
		logic signed [Z_W-1:0] re;
		logic signed [Z_W-1:0] im;
		logic last;
	} otm_z_t;
endpackage : otm_pkg

// ===== verif/otm_encoder_props.sv
/* otm_encoder_props: concurrent checks on the encoder ports.
   assumes: bound into otm_encoder; one clock, i_srst synchronous. */
`timescale 1ns/1ps
module otm_encoder_props (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_sym_valid,
	input wire otm_pkg::otm_sym_cfg_t i_sym_cfg,
	input wire logic o_sym_ready,
	input wire logic i_sc_valid,
	input wire otm_pkg::otm_sc_t i_sc,
	input wire logic o_sc_ready,
	input wire logic i_data_valid,
	input wire logic [3:0] i_data,
	input wire logic o_data_take,
	input wire logic [2:0] o_data_take_cnt,
	input wire logic o_z_valid,
	input wire otm_pkg::otm_z_t o_z,
	input wire logic i_z_ready,
	input wire logic [otm_pkg::SYM_W-1:0] o_sym_index,
	input wire logic [otm_pkg::M_W-1:0] o_pilot_count,
	input wire logic o_cfg_error
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	sequence s_sym;
		i_sym_valid && o_sym_ready;
	endsequence
	sequence s_sc;
		i_sc_valid && o_sc_ready;
	endsequence
	a_pilot_count: assert property (s_sym |=>
		o_pilot_count == $past(i_sym_cfg.m_count) / 12 + ($past(i_sym_cfg.m_count) % 12 >= 3))
		else $error("pilot count wrong");
	a_index_first: assert property (s_sym ##0 i_sym_cfg.first |=> o_sym_index == 1)
		else $error("symbol index not restarted");
	a_index_step: assert property (s_sym ##0 !i_sym_cfg.first |=>
		o_sym_index == $past(o_sym_index) + 1'b1) else $error("symbol index not stepped");
	a_robust_err: assert property (s_sym ##0 (i_sym_cfg.payload && i_sym_cfg.robust
		&& i_sym_cfg.bit_allocation_table > 4'h1) |=> o_cfg_error) else $error("robust table not flagged");
	a_sym_busy: assert property (s_sym |=> !o_sym_ready)
		else $error("config ready inside symbol");
	a_z_latency: assert property (s_sc |=> o_z_valid)
		else $error("output word missing");
	a_z_hold: assert property (o_z_valid && !i_z_ready |=> o_z_valid && $stable(o_z))
		else $error("output word dropped");
	a_mask_zero: assert property (s_sc ##0 !i_sc.kind[1] |=> o_z.re == 0 && o_z.im == 0)
		else $error("masked subcarrier not zero");
	a_take_cnt: assert property (o_data_take |-> o_data_take_cnt inside {3'h1, 3'h2, 3'h4})
		else $error("bad take count");
endmodule : otm_encoder_props
bind otm_encoder otm_encoder_props otm_encoder_props_inst (.*);

// ===== verif/otm_encoder_tb_top.sv
/* otm_encoder_tb_top: self-checking bench with an integer reference model.
   assumes: otm_pkg, otm_encoder and otm_sink_model compiled before it. */
`timescale 1ns/1ps
module otm_encoder_tb_top;
	logic i_clk, i_srst, i_sym_valid, i_sc_valid, i_data_valid, i_z_ready, stall;
	logic o_sym_ready, o_sc_ready, o_data_take, o_z_valid, o_cfg_error;
	logic [3:0] i_data;
	logic [2:0] o_data_take_cnt;
	logic [otm_pkg::SYM_W-1:0] o_sym_index;
	logic [otm_pkg::M_W-1:0] o_pilot_count;
	logic [6:0] pr, ir;
	otm_pkg::otm_sym_cfg_t i_sym_cfg;
	otm_pkg::otm_sc_t i_sc;
	otm_pkg::otm_z_t o_z, ez;
	otm_pkg::otm_z_t zq[$];
	otm_pkg::otm_sc_kind_t kinds[64];
	bit bits[8192];
	bit hdr, ec, seen;
	int n_errors, n_checks, dp, mp, idx, nsc, t, m, p, base, j, tab, ld, cg, cgi;
	int bats[10] = '{0, 1, 2, 4, 5, 6, 7, 3, 4, 1};
	otm_encoder otm_encoder_inst (.*);
	otm_sink_model otm_sink_model_inst (.i_clk(i_clk), .i_stall(stall), .o_ready(i_z_ready));
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	function automatic int pm(bit b);
		return b ? 1 : -1;
	endfunction : pm
	function automatic int q4(bit hi, bit lo);
		return lo ? (hi ? 1 : 3) : (hi ? -1 : -3);
	endfunction : q4
	function automatic logic [6:0] st2(logic [6:0] s);
		s = {s[0] ^ s[3], s[6:1]};
		return {s[0] ^ s[3], s[6:1]};
	endfunction : st2
	function automatic logic signed [otm_pkg::Z_W-1:0] zs(int g, int c, int l);
		return (g * c * l) >>> otm_pkg::CHI_FRAC;
	endfunction : zs
	task automatic chk(input bit ok, input string msg);
		n_checks++;
		if (!ok) begin
			n_errors++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	task automatic model(input otm_pkg::otm_sc_kind_t k);
		int r, n, g, c, l1, l2;
		bit en;
		en = k == otm_pkg::SC_SUPPORTED || (hdr && k == otm_pkg::SC_INACTIVE);
		r = (t + m - base) % m;
		n = 0;
		g = 0;
		c = otm_pkg::CHI_B2;
		if (en && r % 12 == 0 && r < 12 * p) begin
			g = cg;
			l1 = pm(pr[0]);
			l2 = pm(pr[1]);
			pr = st2(pr);
		end else if (k == otm_pkg::SC_INACTIVE && !hdr) begin
			g = cgi;
			l1 = pm(ir[0]);
			l2 = pm(ir[1]);
			ir = st2(ir);
		end else if (en || (k == otm_pkg::SC_REG_MASKED && (tab == 0 || tab == 7))) begin
			n = ld;
			g = en && n > 0 ? cg : 0;
			c = n == 4 ? otm_pkg::CHI_B4 : n == 1 ? otm_pkg::CHI_B1 : otm_pkg::CHI_B2;
			l1 = n == 4 ? q4(bits[mp + 1], bits[mp]) : pm(bits[mp]);
			l2 = n == 4 ? q4(bits[mp + 3], bits[mp + 2]) : n == 2 ? pm(bits[mp + 1]) : 0;
			mp += n;
		end
		t += en;
		ez.re = zs(g, c, l1);
		ez.im = zs(g, c, l2);
		ez.last = idx == nsc - 1;
		zq.push_back(ez);
	endtask : model
	task automatic sym(input bit first, input bit pay, input bit rob, input int bit_allocation_table, input int n);
		int w;
		m = 0;
		for (int i = 0; i < n; i++) begin
			kinds[i] = otm_pkg::otm_sc_kind_t'(first || i == 0 ? 3 : $urandom % 4);
			m += kinds[i] == otm_pkg::SC_SUPPORTED || (!pay && kinds[i] == otm_pkg::SC_INACTIVE);
		end
		cg = $urandom % 4096;
		cgi = $urandom % 4096;
		@(negedge i_clk);
		i_sym_cfg = '{first, pay, rob, bit_allocation_table[3:0], m[8:0], cg[11:0], cgi[11:0]};
		i_sym_valid = 1'b1;
		for (w = 0; w < 50 && o_sym_ready !== 1'b1; w++) @(negedge i_clk);
		if (w == 50) begin
			chk(0, "config timeout");
			results();
		end
		#1;
		hdr = !pay;
		j = first ? 1 : j + 1;
		if (first) pr = 7'h7F;
		if (first) seen = 0;
		if (pay && !seen) ir = 7'h7F;
		seen |= pay;
		tab = hdr || (rob && bit_allocation_table > 1) ? 0 : bit_allocation_table;
		ld = tab == 4 ? 4 : (tab > 4 && tab < 8) ? 1 : (tab == 3 || tab > 7) ? 0 : 2;
		ec = pay && rob && bit_allocation_table > 1 || bit_allocation_table == 3 || bit_allocation_table > 7;
		p = m / 12 + (m % 12 >= 3);
		base = (m % 12 + 3 * (j - 1)) % m;
		t = 0;
		nsc = n;
		idx = 0;
		@(negedge i_clk);
		i_sym_valid = 1'b0;
		chk(o_sym_index === j[11:0] && o_pilot_count === p[8:0] && o_cfg_error === ec, "state");
		for (w = 0; w < 2000 && (idx < nsc || zq.size() > 0); w++) @(negedge i_clk);
		if (w == 2000) begin
			chk(0, "symbol timeout");
			results();
		end
		chk(dp == mp, "bit count");
		$display("symbol %0d done", j);
	endtask : sym
	always @(negedge i_clk) begin
		i_data <= {bits[dp + 3], bits[dp + 2], bits[dp + 1], bits[dp]};
		i_sc <= '{kinds[idx], idx == nsc - 1};
		i_sc_valid <= idx < nsc;
		i_data_valid <= !i_srst && ($urandom % 4 != 0);
	end
	always begin
		@(negedge i_clk);
		#1;
		if (!i_srst && o_data_take) dp += o_data_take_cnt;
		if (!i_srst && i_sc_valid && o_sc_ready) begin
			model(kinds[idx]);
			idx++;
		end
		if (!i_srst && o_z_valid && i_z_ready) begin
			chk(zq.size() > 0 && o_z === zq[0], "output word");
			if (zq.size() > 0)
				void'(zq.pop_front());
		end
	end
	initial begin
		void'($urandom(12461));
		{i_srst, i_sym_valid, stall} = 3'h4;
		i_sym_cfg = '0;
		i_sc = '0;
		i_sc_valid = 1'b0;
		i_data = 4'h0;
		for (int i = 0; i < 8192; i++) bits[i] = $urandom % 2;
		repeat (3) @(negedge i_clk);
		i_srst = 1'b0;
		sym(1, 0, 0, 0, 36);
		for (int i = 0; i < 10; i++) begin
			stall = i[0];
			sym(0, 1, i > 7, bats[i], 30);
		end
		sym(1, 0, 0, 0, 25);
		sym(0, 1, 0, 0, 20);
		results();
	end
endmodule : otm_encoder_tb_top

// ===== verif/otm_sink_model.sv
/* otm_sink_model: downstream modulator side, accepts encoder words.
   assumes: bench samples accepted words; i_stall asks for random back-pressure. */
`timescale 1ns/1ps
module otm_sink_model (
	input wire logic i_clk,
	input wire logic i_stall,
	output logic o_ready
);
	initial o_ready = 1'b1;
	always @(negedge i_clk) begin
		o_ready <= !i_stall || ($urandom % 3 == 0);
	end
endmodule : otm_sink_model
